// File: include/spc_pkg.sv
// package for the system clock and reset sequencing control block
// assumes a single ref_clk domain; all board pins are synchronised inside the block
package spc_pkg;

  // ==========================================================================
  // field widths
  localparam int SPC_MF_W = 12;
  localparam int SPC_DIV_W = 5;
  localparam int SPC_GEAR_W = 3;
  localparam int SPC_MODE_W = 3;

  // ==========================================================================
  // timing
  localparam int SPC_CLK_MHZ = 100;
  localparam int SPC_HARD_RESET_N_CYC = 512;
  localparam int SPC_LOCK_SHORT_CYC = 500;
  localparam int SPC_LOCK_LONG_CYC = 1000;
  localparam logic [11:0] SPC_MF_SHORT_MAX = 12'h004;
  localparam int SPC_POR_MIN_US = 3;
  localparam int SPC_POR_MIN_CYC = SPC_POR_MIN_US * SPC_CLK_MHZ;
  localparam int SPC_CNT_W = 11;

  // ==========================================================================
  // reset configuration
  localparam logic [11:0] SPC_MF_ONE = 12'h000;
  localparam logic [11:0] SPC_MF_FIVE = 12'h004;
  localparam logic [11:0] SPC_MF_SKEW_MAX = 12'h001;
  localparam logic [4:0] SPC_DIV_RST = 5'h00;
  localparam logic [2:0] SPC_GEAR_RST = 3'h0;
  localparam int SPC_MODE_EXT_BIT = 2;

  // control fields set by software
  typedef struct packed {
    logic [SPC_MF_W-1:0] multFactorField;
    logic [SPC_DIV_W-1:0] predivField;
    logic [SPC_GEAR_W-1:0] highGearDivider;
    logic [SPC_GEAR_W-1:0] lowGearDivider;
    logic switchToBackup;
    logic writeStrobe;
  } spc_ctrl_s;

  // status seen by software
  typedef struct packed {
    logic [SPC_MF_W-1:0] multFactorField;
    logic [SPC_DIV_W-1:0] predivField;
    logic [SPC_GEAR_W-1:0] highGearDivider;
    logic [SPC_GEAR_W-1:0] lowGearDivider;
    logic limpEnable;
    logic extRefSelect;
    logic limpMode;
    logic pllLocked;
    logic skewElim;
  } spc_stat_s;

  typedef enum logic [4:0] {
    SPC_POR = 5'h01,
    SPC_LOCKING = 5'h02,
    SPC_HOLD = 5'h04,
    SPC_RUN = 5'h08,
    SPC_LIMP = 5'h10
  } spc_state_e;

  // lock limit depends on multiplication field
  function automatic logic [SPC_CNT_W-1:0] spc_lock_limit(input logic [SPC_MF_W-1:0] mf);
    spc_lock_limit = (mf <= SPC_MF_SHORT_MAX) ? SPC_CNT_W'(SPC_LOCK_SHORT_CYC)
                                              : SPC_CNT_W'(SPC_LOCK_LONG_CYC);
  endfunction

endpackage

// File: hw/spc_sync.sv
// two-flop synchroniser for board level inputs
// assumes the asynchronous input is a level, not a pulse
`timescale 1ns/1ps
module spc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // ==========================================================================
  // first stage is read only by the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // spc_sync

// File: hw/spc_clock_ctrl.sv
// clock module control: reference select, limp mode, PLL lock and hard reset sequencing
// assumes ref_clk is the free running control clock; pll and oscillator status are pins
// How it works
// - multiplication factor equals field value plus one, 1 to 4096
// - reference divided by prediv plus one, times factor, times two gives VCO
// - PLL runs at twice system clock; two phases come from halving it
// - lock expected within 500 input cycles when field at most 4, else 1000
// - hard reset released 512 system cycles after lock
// - lock acquisition starts only after power-on reset is negated
// - power-on reset loads field from mode pins and clears both gear dividers
// - skew elimination only with PLL, field 0 or 1, external reference
// - 1:1 mode pins force multiplication field zero
// - limp enabled and no oscillator at release runs from backup clock
// - in limp system clock is half ring rate, timer clocks twice system
// - limp disabled means no backup clock; wait for oscillator
// - both sources active: system from external input, periodic from crystal
// - supplies timebase and periodic timer clocks besides system clock
// - PLL output held off from reset until first lock
// - every change of lock status can raise a maskable interrupt
`timescale 1ns/1ps
module spc_clock_ctrl (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic power_on_reset_n,
  input wire logic [spc_pkg::SPC_MODE_W-1:0] clock_mode_pins,
  input wire logic pllLockIn,
  input wire logic oscRunning,
  input wire logic extClkActive,
  input wire logic lockIrqMask,
  input wire spc_pkg::spc_ctrl_s ctrl,
  output spc_pkg::spc_stat_s stat,
  output logic hard_reset_n,
  output logic pllOutEnable,
  output logic backupOscEnable,
  output logic useBackupClock,
  output logic sysRefFromExt,
  output logic periodicFromXtal,
  output logic timebaseFromBackup,
  output logic lockChangeIrq,
  output logic lockTimeout
);
  import spc_pkg::*;

  logic porN, lockS, oscS, extS;
  logic [SPC_MODE_W-1:0] modeS;
  spc_state_e state, next_state;
  logic [SPC_CNT_W-1:0] lockCnt;
  logic [SPC_CNT_W-1:0] relCnt;
  logic lockPrev;
  logic [SPC_MODE_W-1:0] modeLatch;

  // ==========================================================================
  // synchronise board pins; straps go through the same flops so they line up with porN
  spc_sync #(.W(4 + SPC_MODE_W)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din({power_on_reset_n, pllLockIn, oscRunning, extClkActive, clock_mode_pins}),
    .dout({porN, lockS, oscS, extS, modeS})
  );

  // decode of mode pins: 1:1 modes and limp enable
  function automatic logic [SPC_MF_W-1:0] mode_mf(input logic [SPC_MODE_W-1:0] m);
    case (m)
      3'h2, 3'h6: mode_mf = SPC_MF_FIVE;
      default: mode_mf = SPC_MF_ONE; // 1:1 modes force zero
    endcase
  endfunction

  function automatic logic mode_limp(input logic [SPC_MODE_W-1:0] m);
    mode_limp = (m == 3'h2) || (m == 3'h3) || (m == 3'h7);
  endfunction

  // ==========================================================================
  // mode pins tracked while reset holds; frozen on release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeLatch <= '0;
    end else begin
      if (!porN) begin
        modeLatch <= modeS;
      end
    end
  end

  // ==========================================================================
  // control fields: reset values forced while power-on reset holds
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat.multFactorField <= SPC_MF_ONE;
      stat.predivField <= SPC_DIV_RST;
      stat.highGearDivider <= SPC_GEAR_RST;
      stat.lowGearDivider <= SPC_GEAR_RST;
    end else if (!porN) begin
      stat.multFactorField <= mode_mf(modeS);
      stat.predivField <= SPC_DIV_RST;
      stat.highGearDivider <= SPC_GEAR_RST;
      stat.lowGearDivider <= SPC_GEAR_RST;
    end else if (ctrl.writeStrobe) begin
      // factor is field plus one and VCO is ref/(div+1)*(mf+1)*2
      stat.multFactorField <= ctrl.multFactorField;
      stat.predivField <= ctrl.predivField;
      stat.highGearDivider <= ctrl.highGearDivider;
      stat.lowGearDivider <= ctrl.lowGearDivider;
    end
  end

  // ==========================================================================
  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      SPC_POR: begin
        if (porN) begin
          // lock starts only after release, limp if limp is enabled and no oscillator
          next_state = (mode_limp(modeLatch) && !oscS) ? SPC_LIMP : SPC_LOCKING;
        end
      end
      SPC_LOCKING: begin
        if (lockS) begin
          next_state = SPC_HOLD;
        end
      end
      SPC_HOLD: begin
        if (!lockS) begin
          next_state = SPC_LOCKING;
        end else if (relCnt == SPC_CNT_W'(SPC_HARD_RESET_N_CYC - 1)) begin
          next_state = SPC_RUN;
        end
      end
      SPC_RUN: begin
        if (ctrl.switchToBackup && mode_limp(modeLatch)) begin
          next_state = SPC_LIMP;
        end
      end
      SPC_LIMP: begin
        // limp is left for the PLL once the oscillator runs while switchToBackup is clear
        if (!ctrl.switchToBackup && oscS) begin
          next_state = SPC_LOCKING;
        end
      end
      default: next_state = SPC_POR;
    endcase
    if (!porN) begin
      next_state = SPC_POR;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SPC_POR;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // release counter restarts on any loss of lock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      relCnt <= '0;
    end else if (state == SPC_HOLD && lockS) begin
      relCnt <= relCnt + SPC_CNT_W'(1);
    end else begin
      relCnt <= '0;
    end
  end

  // ==========================================================================
  // lock watchdog; flags a lock that overran its limit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lockCnt <= '0;
      lockTimeout <= 1'b0;
    end else if (state != SPC_LOCKING) begin
      lockCnt <= '0;
      if (!porN) begin
        lockTimeout <= 1'b0;
      end
    end else if (lockCnt < spc_lock_limit(stat.multFactorField)) begin
      lockCnt <= lockCnt + SPC_CNT_W'(1);
    end else begin
      lockTimeout <= 1'b1;
    end
  end

  // ==========================================================================
  // outputs: all registered
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hard_reset_n <= 1'b0;
      pllOutEnable <= 1'b0;
      backupOscEnable <= 1'b0;
      useBackupClock <= 1'b0;
      sysRefFromExt <= 1'b0;
      periodicFromXtal <= 1'b0;
      timebaseFromBackup <= 1'b0;
    end else begin
      hard_reset_n <= (next_state == SPC_RUN) || (next_state == SPC_LIMP);
      pllOutEnable <= (next_state == SPC_HOLD) || (next_state == SPC_RUN);
      backupOscEnable <= mode_limp(modeLatch) && porN;
      useBackupClock <= next_state == SPC_LIMP;
      timebaseFromBackup <= next_state == SPC_LIMP;
      // external input feeds the system side only when selected and actually clocking
      sysRefFromExt <= modeLatch[SPC_MODE_EXT_BIT] && extS;
      periodicFromXtal <= oscS;
    end
  end

  // ==========================================================================
  // status and lock change interrupt
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lockPrev <= 1'b0;
      lockChangeIrq <= 1'b0;
      stat.limpEnable <= 1'b0;
      stat.extRefSelect <= 1'b0;
      stat.limpMode <= 1'b0;
      stat.pllLocked <= 1'b0;
      stat.skewElim <= 1'b0;
    end else begin
      lockPrev <= lockS;
      lockChangeIrq <= (lockS != lockPrev) && !lockIrqMask;
      stat.limpEnable <= mode_limp(modeLatch);
      stat.extRefSelect <= modeLatch[SPC_MODE_EXT_BIT];
      stat.limpMode <= state == SPC_LIMP;
      stat.pllLocked <= lockS;
      stat.skewElim <= (state == SPC_RUN) && modeLatch[SPC_MODE_EXT_BIT]
                       && (stat.multFactorField <= SPC_MF_SKEW_MAX);
    end
  end

  // ==========================================================================
  // checks
  AST_HARD_RESET_N_AFTER_LOCK: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(hard_reset_n) && !useBackupClock |-> $past(state, 2) == SPC_HOLD)
    else $error("hard reset released without hold");
  AST_HOLD_LEN: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    state == SPC_RUN && $past(state) == SPC_HOLD
      |-> $past(relCnt) == SPC_CNT_W'(SPC_HARD_RESET_N_CYC - 1))
    else $error("release count wrong");
  AST_NO_LOCK_BEFORE_POR: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !porN |=> state == SPC_POR)
    else $error("sequencer left reset early");
  AST_POR_HOLDS_HARD_RESET_N: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !porN |=> !hard_reset_n)
    else $error("hard reset released during power-on reset");
  AST_GEAR_CLR: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !porN |=> stat.highGearDivider == SPC_GEAR_RST && stat.lowGearDivider == SPC_GEAR_RST)
    else $error("gear dividers not cleared");
  AST_ONE_TO_ONE: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !porN && (modeS == 3'h4) |=> stat.multFactorField == SPC_MF_ONE)
    else $error("1:1 mode factor wrong");
  AST_PLL_OFF: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    state == SPC_POR |=> !pllOutEnable)
    else $error("pll output on before lock");
  AST_IRQ: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    lockS != lockPrev && !lockIrqMask |=> lockChangeIrq)
    else $error("lock change missed");
  AST_IRQ_EDGE: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    lockChangeIrq |-> stat.pllLocked != $past(stat.pllLocked))
    else $error("lock change pulse without lock status change");
  AST_LIMP_BACKUP: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    useBackupClock |-> timebaseFromBackup && stat.limpEnable)
    else $error("limp without backup timebase");
  AST_SKEW: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    stat.skewElim |-> stat.extRefSelect)
    else $error("skew elimination without external ref");
endmodule // spc_clock_ctrl

// File: sim/spc_board_model.sv
// board side model: reset circuit, mode straps, oscillator and PLL lock source
// assumes the bench drives its control inputs at the falling edge of ref_clk
`timescale 1ns/1ps
module spc_board_model #(
  parameter int POR_HOLD = 300 // 3 us at 100 MHz
) (
  input wire logic ref_clk,
  input wire logic keepAliveOk,
  input wire logic [2:0] modeIn,
  input wire logic oscOk,
  input wire logic lockDrop,
  input wire logic [15:0] lockDelay,
  output logic power_on_reset_n,
  output logic [2:0] clock_mode_pins,
  output logic pllLockIn,
  output logic oscRunning,
  output logic extClkActive
);
  // ==========================================================================
  // reset circuit
  int holdCnt = 0;
  int lockCnt = 0;
  logic [2:0] modeHeld = 3'h0;

  // hold count restarts whenever keep-alive drops; shortened count stands for start-up
  always @(negedge ref_clk) begin
    if (!keepAliveOk) holdCnt <= 0;
    else if (holdCnt < POR_HOLD) holdCnt <= holdCnt + 1;
  end
  assign power_on_reset_n = keepAliveOk && (holdCnt >= POR_HOLD);

  // straps follow the bench while reset is low, then stay frozen
  always @(negedge ref_clk) begin
    if (!power_on_reset_n) modeHeld <= modeIn;
  end
  assign clock_mode_pins = power_on_reset_n ? modeHeld : modeIn;

  // ==========================================================================
  // reference and lock source
  // lock needs a running reference and a released reset; a drop restarts the wait
  always @(negedge ref_clk) begin
    if (!power_on_reset_n || !oscOk || lockDrop) lockCnt <= 0;
    else if (lockCnt < 60000) lockCnt <= lockCnt + 1;
  end
  assign pllLockIn = power_on_reset_n && oscOk && !lockDrop && (lockCnt >= lockDelay);
  assign oscRunning = oscOk;
  assign extClkActive = clock_mode_pins[2];
endmodule // spc_board_model

// File: sim/tb.sv
// self-checking bench for the clock and reset sequencing control block
// assumes the board model supplies every pin level; bench drives at falling edges
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; \
  if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, (g), (e)); end end
module tb;
  import spc_pkg::*;
  // ==========================================================================
  // wiring
  logic ref_clk;
  logic arst_n;
  logic keepAliveOk;
  logic oscOk;
  logic lockDrop;
  logic lockIrqMask;
  logic [2:0] modeIn;
  logic [2:0] mm;
  logic [15:0] lockDelay;
  spc_ctrl_s ctrl;
  spc_stat_s stat;
  wire logic power_on_reset_n;
  wire logic [2:0] clock_mode_pins;
  wire logic pllLockIn;
  wire logic oscRunning;
  wire logic extClkActive;
  logic hard_reset_n;
  logic pllOutEnable;
  logic backupOscEnable;
  logic useBackupClock;
  logic sysRefFromExt;
  logic periodicFromXtal;
  logic timebaseFromBackup;
  logic lockChangeIrq;
  logic lockTimeout;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int irqCount = 0;
  int base;

  spc_clock_ctrl spc_clock_ctrl_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .power_on_reset_n(power_on_reset_n), .clock_mode_pins(clock_mode_pins),
    .pllLockIn(pllLockIn), .oscRunning(oscRunning), .extClkActive(extClkActive),
    .lockIrqMask(lockIrqMask), .ctrl(ctrl), .stat(stat), .hard_reset_n(hard_reset_n),
    .pllOutEnable(pllOutEnable), .backupOscEnable(backupOscEnable),
    .useBackupClock(useBackupClock), .sysRefFromExt(sysRefFromExt),
    .periodicFromXtal(periodicFromXtal), .timebaseFromBackup(timebaseFromBackup),
    .lockChangeIrq(lockChangeIrq), .lockTimeout(lockTimeout));

  spc_board_model spc_board_model_inst (.ref_clk(ref_clk), .keepAliveOk(keepAliveOk),
    .modeIn(modeIn), .oscOk(oscOk), .lockDrop(lockDrop), .lockDelay(lockDelay),
    .power_on_reset_n(power_on_reset_n), .clock_mode_pins(clock_mode_pins),
    .pllLockIn(pllLockIn), .oscRunning(oscRunning), .extClkActive(extClkActive));

  // ==========================================================================
  // clock, event counting and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ceiling is nearly four times the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (lockChangeIrq === 1'b1) irqCount++;
    if (cycles == 40000) begin
      bad_count++;
      end_sim();
    end
  end

  // ==========================================================================
  // expectations and access tasks
  function automatic logic [11:0] expMf(input logic [2:0] m);
    return (m == 3'h2 || m == 3'h6) ? 12'h004 : 12'h000;
  endfunction

  function automatic logic expLimp(input logic [2:0] m);
    return m == 3'h2 || m == 3'h3 || m == 3'h7;
  endfunction

  // power cycle with a write attempt that must be ignored while reset is low
  task automatic por(input logic [2:0] m, input logic osc, input logic [15:0] d);
    int n;
    n = 0;
    keepAliveOk = 1'b0;
    modeIn = m;
    oscOk = osc;
    lockDelay = d;
    repeat (6) @(negedge ref_clk);
    ctrl.multFactorField = 12'habc;
    ctrl.writeStrobe = 1'b1;
    @(negedge ref_clk);
    ctrl.writeStrobe = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK(stat.multFactorField, expMf(m))
    `CHK(stat.highGearDivider, SPC_GEAR_RST)
    `CHK(stat.lowGearDivider, SPC_GEAR_RST)
    `CHK(stat.predivField, SPC_DIV_RST)
    `CHK(hard_reset_n, 1'b0)
    keepAliveOk = 1'b1;
    while (power_on_reset_n !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(pllOutEnable, 1'b0)
  endtask

  task automatic waitLock();
    int n;
    n = 0;
    while (pllLockIn !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // release lands 512 cycles after lock plus the synchroniser delay
  task automatic relChk();
    repeat (500) @(negedge ref_clk);
    `CHK(hard_reset_n, 1'b0)
    repeat (20) @(negedge ref_clk);
    `CHK(hard_reset_n, 1'b1)
    `CHK(pllOutEnable, 1'b1)
  endtask

  task automatic wr(input logic [11:0] mf, input logic [4:0] pd, input logic [2:0] g);
    ctrl.multFactorField = mf;
    ctrl.predivField = pd;
    ctrl.highGearDivider = g;
    ctrl.lowGearDivider = ~g;
    ctrl.writeStrobe = 1'b1;
    @(negedge ref_clk);
    ctrl.writeStrobe = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(stat.multFactorField, mf)
    `CHK(stat.predivField, pd)
    `CHK(stat.highGearDivider, g)
    `CHK(stat.lowGearDivider, ~g)
  endtask

  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    keepAliveOk = 1'b0;
    oscOk = 1'b0;
    lockDrop = 1'b0;
    lockIrqMask = 1'b1;
    modeIn = 3'h0;
    lockDelay = 16'd30;
    ctrl = '0;
    repeat (4) @(negedge ref_clk);
    arst_n = 1'b1;
    base = irqCount;
    for (int m = 0; m < 8; m++) begin
      mm = 3'(m);
      por(mm, 1'b1, 16'd30);
      waitLock();
      relChk();
      `CHK(stat.limpEnable, expLimp(mm))
      `CHK(stat.limpMode, 1'b0)
      `CHK(sysRefFromExt, mm[2])
      `CHK(stat.extRefSelect, mm[2])
      `CHK(stat.pllLocked, 1'b1)
      `CHK(periodicFromXtal, 1'b1)
      `CHK(stat.skewElim, mm[2] && expMf(mm) <= SPC_MF_SKEW_MAX)
      `CHK(lockTimeout, 1'b0)
      if (!expLimp(mm)) `CHK(backupOscEnable, 1'b0)
    end
    `CHK(irqCount, base)
    wr(12'hfff, 5'h1f, 3'h5);
    wr(12'h000, 5'h00, 3'h0);
    // lock lost mid-count: the release count must start over
    por(3'h1, 1'b1, 16'd30);
    lockIrqMask = 1'b0;
    base = irqCount;
    waitLock();
    repeat (200) @(negedge ref_clk);
    lockDrop = 1'b1;
    repeat (10) @(negedge ref_clk);
    lockDrop = 1'b0;
    waitLock();
    relChk();
    `CHK(irqCount - base, 3)
    lockIrqMask = 1'b1;
    // slow lock overruns the short limit
    por(3'h1, 1'b1, 16'd600);
    waitLock();
    `CHK(lockTimeout, 1'b1)
    // limp start without oscillator, then over to the PLL and back
    por(3'h3, 1'b0, 16'd30);
    repeat (10) @(negedge ref_clk);
    `CHK(useBackupClock, 1'b1)
    `CHK(backupOscEnable, 1'b1)
    `CHK(timebaseFromBackup, 1'b1)
    `CHK(stat.limpMode, 1'b1)
    `CHK(hard_reset_n, 1'b1)
    oscOk = 1'b1;
    waitLock();
    repeat (600) @(negedge ref_clk);
    `CHK(useBackupClock, 1'b0)
    `CHK(timebaseFromBackup, 1'b0)
    ctrl.switchToBackup = 1'b1;
    repeat (10) @(negedge ref_clk);
    `CHK(useBackupClock, 1'b1)
    // switch request refused when limp mode is disabled
    por(3'h1, 1'b1, 16'd30);
    waitLock();
    relChk();
    `CHK(useBackupClock, 1'b0)
    ctrl.switchToBackup = 1'b0;
    end_sim();
  end
endmodule // tb
